// File: core/sign_supervisor.sv
// Communication supervisor of a message_sign controller: loss timer, deadlines,
// display parameters, default message choice and processor watchdog, on APB.
// Assumes request strobes come from same-clock logic; switches come from pins.
`timescale 1ns/1ps
`include "sign_supervisor_defines.svh"

// Function
// - Timeout programmable one to sixty minutes
// - Keypad or laptop can disable timeout
// - Last enable choice persists as default
// - Minute timer restarts on each good request
// - Timer period defaults to ten minutes
// - Expiry enters communication-loss state
// - Every request answered within five seconds
// - Dwell in tenths, zero to five seconds
// - Blank in tenths, zero to ten seconds
// - Default message chosen by failure type
// - Message shown within two seconds
// - Message tag overrides configured dwell
// - Backup power enters power-loss state
// - Two fonts, four images, one shown
// - All readable, state gates writes
// - Watchdog resets processor on failure
// - Loss shows message, stops timer
// - Local mode discards central updates
module sign_supervisor
  import sign_supervisor_pkg::*;
#(
  parameter int unsigned MINUTE_CYCLES = 32'(`MINUTE_CYC),
  parameter int unsigned RESP_CYCLES   = 32'(`RESP_CYC),
  parameter int unsigned DISP_CYCLES   = 32'(`DISP_CYC),
  parameter int unsigned KICK_CYCLES   = 32'(`KICK_CYC)
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        req_ok_i,        // Correctly formed central request
  input  wire logic        req_update_i,    // That request writes an object
  input  wire logic        resp_done_i,     // Answer sent
  input  wire logic        msg_rx_done_i,   // Complete display request received
  input  wire logic        msg_shown_i,     // Message now on the sign
  input  wire logic        override_cmd_i,  // Central override command
  input  wire logic        local_off_cmd_i, // Central local-off command
  input  wire logic        tag_dwell_vld_i, // Message carries its own dwell tag
  input  wire logic [5:0]  tag_dwell_i,
  input  wire logic        power_fail_i,    // Pin: running on backup power
  input  wire logic        local_sw_i,      // Pin: field local switch
  input  wire logic        kp_tmo_on_i,     // Pin: keypad enables timeout
  input  wire logic        kp_tmo_off_i,    // Pin: keypad disables timeout
  output logic      [4:0]  state_o,
  output logic             req_accept_o,
  output logic             resp_timeout_o,
  output logic             wdog_reset_o,
  output logic             show_default_o,
  output logic      [7:0]  default_msg_o,
  output logic      [5:0]  dwell_o,
  output logic      [6:0]  blank_o,
  output logic             font_o,
  output logic      [1:0]  graphic_o,
  output logic             graphic_on_o,
  output logic             tmo_en_o
);

  // Refuse counts the counters cannot serve
  if (MINUTE_CYCLES < 2 || RESP_CYCLES < 2 || DISP_CYCLES < 2 || KICK_CYCLES < 2) begin : g_chk
    $error("sign_supervisor: cycle counts must be at least 2");
  end

  // Saturating clamp shared by the parameter writes
  function automatic logic [6:0] clamp7(input logic [31:0] v, input logic [6:0] hi);
    clamp7 = (v > 32'(hi)) ? hi : v[6:0];
  endfunction

  sup_state_t s_reg;                           // Present state
  sup_state_t s_next;                          // Next state
  logic       wr_en;                           // Write takes effect this edge
  logic       rd_en;                           // Read answered this edge
  logic       tick;                            // One-minute tick
  logic       running;                         // Loss timer is live
  logic [5:0] min_w;                           // Requested timeout, clamped

  assign tick    = (s_reg.presc == MINUTE_CYCLES - 1);
  assign running = s_reg.tmo_en && !(s_reg.st inside {ST_COMM_LOSS, ST_PWR_LOSS});
  assign wr_en   = psel_i && penable_i && s_reg.pready && pwrite_i;
  assign rd_en   = psel_i && penable_i && !s_reg.pready;

  // Clamp into one to sixty minutes
  assign min_w = (pwdata_i[`CTRL_MIN_LSB +: 6] < `TMO_MIN_LO) ? `TMO_MIN_LO :
                 6'(clamp7({26'h0, pwdata_i[`CTRL_MIN_LSB +: 6]}, 7'(`TMO_MIN_HI)));

  // Next-state logic for the whole block
  always_comb begin
    s_next = s_reg;
    // Synchroniser chains; first stage feeds only the second
    s_next.pf_sync = {s_reg.pf_sync[0], power_fail_i};
    s_next.lo_sync = {s_reg.lo_sync[0], local_sw_i};
    s_next.ke_sync = {s_reg.ke_sync[1:0], kp_tmo_on_i};
    s_next.kd_sync = {s_reg.kd_sync[1:0], kp_tmo_off_i};

    // Keypad choice; stored flag is the persistent default
    if (s_reg.kd_sync[1] && !s_reg.kd_sync[2]) begin
      s_next.tmo_en = 1'b0;
    end else if (s_reg.ke_sync[1] && !s_reg.ke_sync[2]) begin
      s_next.tmo_en = 1'b1;
    end

    // Minute prescaler, free running while the timer is live
    if (!running || tick) begin
      s_next.presc = 32'h0;
    end else begin
      s_next.presc = s_reg.presc + 32'h1;
    end

    // Minute count, restart on good request
    if (req_ok_i || !running) begin
      s_next.min_cnt = 6'h00;
      if (req_ok_i) begin
        s_next.presc = 32'h0;
      end
    end else if (tick) begin
      s_next.min_cnt = s_reg.min_cnt + 6'h01;
    end

    // Controller state transitions, power loss first
    case (s_reg.st)
      ST_PWR_LOSS: if (!s_reg.pf_sync[1]) begin
        s_next.st = ST_CENTRAL;
      end
      ST_COMM_LOSS: if (req_ok_i) begin
        s_next.st = s_reg.lo_sync[1] ? ST_LOCAL : ST_CENTRAL;
      end
      ST_LOCAL: if (override_cmd_i) begin
        s_next.st = ST_OVERRIDE;
      end else if (!s_reg.lo_sync[1] || local_off_cmd_i) begin
        s_next.st = ST_CENTRAL;
      end
      ST_OVERRIDE: if (local_off_cmd_i || !s_reg.lo_sync[1]) begin
        s_next.st = ST_CENTRAL;
      end
      ST_CENTRAL: if (s_reg.lo_sync[1]) begin
        s_next.st = ST_LOCAL;
      end
      default: s_next.st = ST_CENTRAL;
    endcase
    // Expiry when count reaches timeout
    if (running && !req_ok_i && tick && (s_reg.min_cnt + 6'h01 == s_reg.tmo_min)) begin
      s_next.st = ST_COMM_LOSS;
    end
    if (s_reg.pf_sync[1]) begin
      s_next.st = ST_PWR_LOSS;
    end

    // Answer deadline; a new request restarts it
    s_next.resp_to = 1'b0;
    if (req_ok_i) begin
      s_next.resp_busy = 1'b1;
      s_next.resp_cnt  = 32'h0;
    end else if (resp_done_i) begin
      s_next.resp_busy = 1'b0;
    end else if (s_reg.resp_busy) begin
      if (s_reg.resp_cnt == RESP_CYCLES - 1) begin
        s_next.resp_busy = 1'b0;
        s_next.resp_to   = 1'b1;
      end else begin
        s_next.resp_cnt = s_reg.resp_cnt + 32'h1;
      end
    end

    // Display latency deadline
    if (msg_rx_done_i) begin
      s_next.disp_busy = 1'b1;
      s_next.disp_cnt  = 32'h0;
    end else if (msg_shown_i) begin
      s_next.disp_busy = 1'b0;
    end else if (s_reg.disp_busy) begin
      s_next.disp_cnt = s_reg.disp_cnt + 32'h1;
      if (s_reg.disp_cnt == DISP_CYCLES - 1) begin
        s_next.disp_busy = 1'b0;
      end
    end

    // Processor watchdog; a kick write restarts it
    s_next.wd_rst = 1'b0;
    if (wr_en && paddr_i == `REG_KICK) begin
      s_next.wd_cnt = 32'h0;
    end else if (s_reg.wd_cnt == KICK_CYCLES - 1) begin
      s_next.wd_cnt = 32'h0;
      s_next.wd_rst = 1'b1;
    end else begin
      s_next.wd_cnt = s_reg.wd_cnt + 32'h1;
    end

    // APB: one wait state, write lands when pready is seen
    s_next.pready  = rd_en;
    s_next.pslverr = 1'b0;
    if (rd_en) begin
      case (paddr_i)
        `REG_CTRL:    s_next.prdata = {18'h0, s_reg.tmo_min, 7'h0, s_reg.tmo_en};
        `REG_DWELL:   s_next.prdata = {26'h0, s_reg.dwell};
        `REG_BLANK:   s_next.prdata = {25'h0, s_reg.blank};
        `REG_DEFMSG:  s_next.prdata = {7'h0, s_reg.pwr_vld, s_reg.pwr_msg,
                                       7'h0, s_reg.comm_vld, s_reg.comm_msg};
        `REG_DISPLAY: s_next.prdata = {28'h0, s_reg.gfx_on, s_reg.gfx, s_reg.font};
        `REG_STATUS:  s_next.prdata = {14'h0, s_reg.disp_busy, s_reg.resp_busy,
                                       2'h0, s_reg.min_cnt, 3'h0, s_reg.st};
        `REG_KICK:    s_next.prdata = 32'h0;
        `REG_EVENTS:  s_next.prdata = {29'h0, s_reg.flags};
        default: begin
          s_next.prdata  = 32'h0;
          s_next.pslverr = 1'b1;                             // Unmapped
        end
      endcase
      // Dwell, blank and display writes refused while on backup power
      if (pwrite_i && s_reg.st == ST_PWR_LOSS &&
          paddr_i inside {`REG_DWELL, `REG_BLANK, `REG_DISPLAY}) begin
        s_next.pslverr = 1'b1;
      end
      if (pwrite_i && paddr_i == `REG_STATUS) begin
        s_next.pslverr = 1'b1;
      end
    end
    if (wr_en && !s_reg.pslverr) begin
      case (paddr_i)
        `REG_CTRL: begin
          s_next.tmo_en  = pwdata_i[`CTRL_EN_BIT];
          s_next.tmo_min = min_w;
        end
        `REG_DWELL:   s_next.dwell = 6'(clamp7(pwdata_i, 7'(`DWELL_MAX)));
        `REG_BLANK:   s_next.blank = clamp7(pwdata_i, `BLANK_MAX);
        `REG_DEFMSG: begin
          s_next.comm_msg = pwdata_i[7:0];
          s_next.comm_vld = pwdata_i[`DEF_COMM_VLD];
          s_next.pwr_msg  = pwdata_i[`DEF_PWR_LSB +: 8];
          s_next.pwr_vld  = pwdata_i[`DEF_PWR_VLD];
        end
        `REG_DISPLAY: begin
          s_next.font   = pwdata_i[0];
          s_next.gfx    = pwdata_i[2:1];
          s_next.gfx_on = pwdata_i[3];
        end
        `REG_EVENTS:  s_next.flags = s_reg.flags & ~pwdata_i[2:0];
        default: s_next.flags = s_next.flags;
      endcase
    end
    // Sticky events; setting wins over a clear in the same cycle
    s_next.flags = s_next.flags | {s_next.wd_rst,
                   s_reg.disp_busy && !msg_shown_i && !msg_rx_done_i &&
                   s_reg.disp_cnt == DISP_CYCLES - 1, s_next.resp_to};

    // Default message chosen by failure type
    case (s_next.st)
      ST_COMM_LOSS: begin
        s_next.show_def = s_next.comm_vld;
        s_next.def_msg  = s_next.comm_msg;
      end
      ST_PWR_LOSS: begin
        s_next.show_def = s_next.pwr_vld;
        s_next.def_msg  = s_next.pwr_msg;
      end
      default: begin
        s_next.show_def = 1'b0;
        s_next.def_msg  = 8'h00;
      end
    endcase
    // Tag in message beats configured dwell
    s_next.dwell_out = tag_dwell_vld_i ? 6'(clamp7({26'h0, tag_dwell_i}, 7'(`DWELL_MAX)))
                                       : s_next.dwell;
    s_next.req_acc = req_update_i && s_reg.st != ST_LOCAL;
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg         <= '0;
      s_reg.st      <= ST_CENTRAL;
      s_reg.tmo_en  <= `TMO_EN_RST;
      s_reg.tmo_min <= `TMO_MIN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign prdata_o       = s_reg.prdata;
  assign pready_o       = s_reg.pready;
  assign pslverr_o      = s_reg.pslverr;
  assign state_o        = s_reg.st;
  assign req_accept_o   = s_reg.req_acc;
  assign resp_timeout_o = s_reg.resp_to;
  assign wdog_reset_o   = s_reg.wd_rst;
  assign show_default_o = s_reg.show_def;
  assign default_msg_o  = s_reg.def_msg;
  assign dwell_o        = s_reg.dwell_out;
  assign blank_o        = s_reg.blank;
  assign font_o         = s_reg.font;
  assign graphic_o      = s_reg.gfx;
  assign graphic_on_o   = s_reg.gfx_on;
  assign tmo_en_o       = s_reg.tmo_en;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence s_expire;
    running && !req_ok_i && tick && (s_reg.min_cnt + 6'h01 == s_reg.tmo_min) &&
    !s_reg.pf_sync[1];
  endsequence
  sequence s_kick_missed;
    s_reg.wd_cnt == KICK_CYCLES - 1 && !(wr_en && paddr_i == `REG_KICK);
  endsequence

  tmo_range_a: assert property (s_reg.tmo_min >= `TMO_MIN_LO && s_reg.tmo_min <= `TMO_MIN_HI)
    else $error("timeout out of range");
  tmo_off_a: assert property ((!s_reg.tmo_en && s_reg.st != ST_COMM_LOSS) |=>
    s_reg.st != ST_COMM_LOSS) else $error("loss entered while disabled");
  restart_a: assert property ((req_ok_i && running) |=> s_reg.min_cnt == 6'h00)
    else $error("timer not restarted");
  expire_a: assert property (s_expire |=> s_reg.st == ST_COMM_LOSS)
    else $error("expiry missed");
  resp_late_a: assert property ((s_reg.resp_busy && !req_ok_i && !resp_done_i &&
    s_reg.resp_cnt == RESP_CYCLES - 1) |=> resp_timeout_o ##1 !resp_timeout_o)
    else $error("answer deadline missed");
  dwell_lim_a: assert property (s_reg.dwell <= `DWELL_MAX)
    else $error("dwell beyond limit");
  blank_lim_a: assert property (s_reg.blank <= `BLANK_MAX)
    else $error("blank beyond limit");
  loss_msg_a: assert property ((s_reg.st == ST_COMM_LOSS && s_reg.comm_vld) |->
    show_default_o && default_msg_o == s_reg.comm_msg) else $error("loss message wrong");
  local_drop_a: assert property ((s_reg.st == ST_LOCAL && req_update_i) |=>
    !req_accept_o) else $error("local update accepted");
  wdog_fire_a: assert property (s_kick_missed |=> wdog_reset_o && s_reg.flags[2])
    else $error("watchdog silent");

endmodule // sign_supervisor

// File: core/sign_supervisor_defines.svh
// Offsets, field positions, reset values and timing counts of the sign supervisor.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
`ifndef SIGN_SUPERVISOR_DEFINES_SVH
`define SIGN_SUPERVISOR_DEFINES_SVH
// Register byte offsets
`define REG_CTRL        8'h00
`define REG_DWELL       8'h04
`define REG_BLANK       8'h08
`define REG_DEFMSG      8'h0C
`define REG_DISPLAY     8'h10
`define REG_STATUS      8'h14
`define REG_KICK        8'h18
`define REG_EVENTS      8'h1C
// Field positions
`define CTRL_EN_BIT     0
`define CTRL_MIN_LSB    8
`define DEF_COMM_VLD    8
`define DEF_PWR_LSB     16
`define DEF_PWR_VLD     24
// Reset values and limits
`define TMO_EN_RST      1'b1
`define TMO_MIN_RST     6'h0A
`define TMO_MIN_LO      6'h01
`define TMO_MIN_HI      6'h3C
`define DWELL_MAX       6'h32
`define BLANK_MAX       7'h64
// Timing
`define CLK_HZ          64'd25000000
`define MINUTE_S        64'd60
`define RESP_S          64'd5
`define DISP_S          64'd2
`define KICK_S          64'd4
`define MINUTE_CYC      (`CLK_HZ * `MINUTE_S)
`define RESP_CYC        (`CLK_HZ * `RESP_S)
`define DISP_CYC        (`CLK_HZ * `DISP_S)
`define KICK_CYC        (`CLK_HZ * `KICK_S)
`endif

// File: core/sign_supervisor_pkg.sv
// Types of the sign supervisor: controller states and the whole state record.
// Assumes nothing from the defines header; every number here is a literal.
package sign_supervisor_pkg;
  // Controller state, one-hot
  typedef enum logic [4:0] {
    ST_CENTRAL   = 5'b00001,
    ST_LOCAL     = 5'b00010,
    ST_OVERRIDE  = 5'b00100,
    ST_COMM_LOSS = 5'b01000,
    ST_PWR_LOSS  = 5'b10000
  } ctl_state_t;

  // Complete registered state of the supervisor
  typedef struct packed {
    ctl_state_t  st;
    logic [1:0]  pf_sync;      // Power-fail synchroniser
    logic [1:0]  lo_sync;      // Local switch synchroniser
    logic [2:0]  ke_sync;      // Keypad enable, last stage for edge
    logic [2:0]  kd_sync;      // Keypad disable, last stage for edge
    logic        tmo_en;
    logic [5:0]  tmo_min;
    logic [5:0]  min_cnt;
    logic [31:0] presc;
    logic [7:0]  comm_msg;
    logic        comm_vld;
    logic [7:0]  pwr_msg;
    logic        pwr_vld;
    logic [5:0]  dwell;
    logic [6:0]  blank;
    logic        font;
    logic [1:0]  gfx;
    logic        gfx_on;
    logic        resp_busy;
    logic [31:0] resp_cnt;
    logic        disp_busy;
    logic [31:0] disp_cnt;
    logic [31:0] wd_cnt;
    logic [2:0]  flags;        // Sticky: watchdog, display late, answer late
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        resp_to;
    logic        wd_rst;
    logic        show_def;
    logic [7:0]  def_msg;
    logic [5:0]  dwell_out;
    logic        req_acc;
  } sup_state_t;
endpackage

// File: sim/central_model.sv
// Central facility model: issues requests, answers after a set delay,
// and gives a request up as failed when the answer is too late.
// Assumes the bench pulses send_i for one cycle after a rising edge.
`timescale 1ns/1ps
module central_model #(
  parameter int unsigned RESP_LIMIT = 16
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       send_i,       // Start one request
  input  wire logic       upd_i,        // Request writes an object
  input  wire logic [7:0] ans_dly_i,    // Cycles until the answer
  output logic            req_ok_o,
  output logic            req_update_o,
  output logic            resp_done_o,
  output logic            req_failed_o  // Sticky until next request
);
  int cnt;  // Cycles waited, 0 when idle

  // Request, answer and give-up bookkeeping
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt          <= 0;
      req_ok_o     <= 1'b0;
      req_update_o <= 1'b0;
      resp_done_o  <= 1'b0;
      req_failed_o <= 1'b0;
    end else begin
      req_ok_o     <= send_i;
      req_update_o <= send_i & upd_i;
      resp_done_o  <= 1'b0;
      if (cnt > 0) begin
        cnt <= cnt + 1;
      end
      // Late answer still goes out, but the request already counts as lost
      if (cnt == int'(RESP_LIMIT) + 1) begin
        req_failed_o <= 1'b1;
      end
      if (cnt > 0 && cnt == int'(ans_dly_i)) begin
        resp_done_o <= 1'b1;
        cnt         <= 0;
      end
      if (send_i) begin
        cnt          <= 1;
        req_failed_o <= 1'b0;
      end
    end
  end
endmodule // central_model

// File: sim/tb_sign_supervisor.sv
// Self-checking bench of the sign supervisor with short timing parameters.
// Assumes the central facility model drives the request strobes.
`timescale 1ns/1ps
`include "sign_supervisor_defines.svh"
module tb_sign_supervisor;
  import sign_supervisor_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, send, upd;
  logic [7:0]  paddr, dly, dmsg;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  st;
  logic [5:0]  tagd, dwo;
  logic [6:0]  blo;
  logic [1:0]  gfx;
  logic        rok, rup, rdn, rfail, rxd, shw, ovr, tagv, pf, lsw, kon, koff, acc, rto;
  logic        wdr, sdef, fnt, gon, ten, err, loff;
  int          err_count, num_checks, n;

  sign_supervisor #(.MINUTE_CYCLES(20), .RESP_CYCLES(16), .DISP_CYCLES(12),
    .KICK_CYCLES(40)) u_sign_supervisor (.clk_sys_i(clk), .rstn_i(rstn),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .req_ok_i(rok), .req_update_i(rup), .resp_done_i(rdn), .msg_rx_done_i(rxd),
    .msg_shown_i(shw), .override_cmd_i(ovr), .local_off_cmd_i(loff),
    .tag_dwell_vld_i(tagv), .tag_dwell_i(tagd), .power_fail_i(pf), .local_sw_i(lsw),
    .kp_tmo_on_i(kon), .kp_tmo_off_i(koff), .state_o(st), .req_accept_o(acc),
    .resp_timeout_o(rto), .wdog_reset_o(wdr), .show_default_o(sdef),
    .default_msg_o(dmsg), .dwell_o(dwo), .blank_o(blo), .font_o(fnt),
    .graphic_o(gfx), .graphic_on_o(gon), .tmo_en_o(ten));
  central_model #(.RESP_LIMIT(16)) u_central_model (.clk_sys_i(clk), .rstn_i(rstn),
    .send_i(send), .upd_i(upd), .ans_dly_i(dly), .req_ok_o(rok),
    .req_update_o(rup), .resp_done_o(rdn), .req_failed_o(rfail));

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; holds everything until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait count assumed; only the hang guard ends a lost answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic req(input logic u, input logic [7:0] d);
    @(posedge clk);
    send <= 1'b1;
    upd <= u;
    dly <= d;
    @(posedge clk);
    send <= 1'b0;
  endtask

  // Clamp table for the timeout minutes
  task automatic t_ctrl();
    logic [5:0] wv[4] = '{6'h00, 6'h3D, 6'h03, 6'h3C};
    logic [5:0] ev[4] = '{6'h01, 6'h3C, 6'h03, 6'h3C};
    apb(0, `REG_CTRL, 0);
    chk("ctrl reset", 32'h0A01, rd & 32'h3F01);
    chk("state reset", 32'h01, st);
    for (int i = 0; i < 4; i++) begin
      apb(1, `REG_CTRL, {18'h0, wv[i], 8'h01});
      apb(0, `REG_CTRL, 0);
      chk("ctrl minutes", ev[i], rd[13:8]);
    end
  endtask

  // Dwell and blank clamps, message tag precedence
  task automatic t_dwell();
    apb(1, `REG_DWELL, 32'h3F);
    apb(1, `REG_BLANK, 32'h7F);
    cyc(2);
    chk("dwell clamp", 32'h32, dwo);
    chk("blank clamp", 32'h64, blo);
    apb(1, `REG_DWELL, 32'h14);
    tagv <= 1'b1;
    tagd <= 6'h09;
    cyc(3);
    chk("dwell tag", 32'h09, dwo);
    tagv <= 1'b0;
    cyc(3);
    chk("dwell reg", 32'h14, dwo);
  endtask

  // Font and image selection, display deadline
  task automatic t_disp();
    apb(1, `REG_DISPLAY, 32'hA);
    cyc(2);
    chk("font image show", 32'h3, {fnt, gfx, gon});
    apb(1, `REG_EVENTS, 32'h7);
    rxd <= 1'b1;
    cyc(1);
    rxd <= 1'b0;
    cyc(3);
    shw <= 1'b1;
    cyc(1);
    shw <= 1'b0;
    cyc(20);
    apb(0, `REG_EVENTS, 0);
    chk("display in time", 0, rd[1]);
    rxd <= 1'b1;
    cyc(1);
    rxd <= 1'b0;
    cyc(20);
    apb(0, `REG_EVENTS, 0);
    chk("display late", 1, rd[1]);
  endtask

  // Answer deadline, prompt then late
  task automatic t_resp();
    apb(1, `REG_EVENTS, 32'h7);
    req(0, 8'd4);
    n = 0;
    while (rto !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    chk("prompt answer", 30, n);
    req(0, 8'd40);
    n = 0;
    while (rto !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
    end
    chk("late answer flagged", 1, n > 12 && n < 21);
    cyc(4);
    chk("requester gave up", 1, rfail);
    apb(0, `REG_EVENTS, 0);
    chk("answer late event", 1, rd[0]);
    apb(1, `REG_EVENTS, 32'h1);
    apb(0, `REG_EVENTS, 0);
    chk("event cleared", 0, rd[0]);
    cyc(30);
  endtask

  // Keypad disable and enable of the timeout
  task automatic t_kpad();
    koff <= 1'b1;
    cyc(6);
    koff <= 1'b0;
    chk("kp off", 0, ten);
    apb(0, `REG_CTRL, 0);
    chk("ctrl en kept", 0, rd[0]);
    kon <= 1'b1;
    cyc(6);
    kon <= 1'b0;
    chk("kp on", 1, ten);
  endtask

  // Loss timer: restart, expiry, stop in loss, recovery
  task automatic t_loss();
    apb(1, `REG_DEFMSG, 32'h01A5015A);
    apb(1, `REG_CTRL, 32'h0201);
    for (int i = 0; i < 3; i++) begin
      req(0, 8'd2);
      cyc(30);
    end
    chk("restart keeps central", 32'h01, st);
    n = 0;
    while (st !== 5'h08 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("loss entry window", 1, n > 5 && n < 14);
    chk("comm default", 32'h15A, {sdef, dmsg});
    cyc(50);
    apb(0, `REG_STATUS, 0);
    chk("timer stopped", 32'h08, {rd[13:8], rd[4:0]});
    apb(1, `REG_CTRL, 32'h3C01);
    req(0, 8'd2);
    cyc(3);
    chk("recover central", 32'h01, st);
  endtask

  // Backup power state, write gating, refused addresses
  task automatic t_power();
    pf <= 1'b1;
    cyc(6);
    chk("power state", 32'h10, st);
    chk("power default", 32'h1A5, {sdef, dmsg});
    apb(1, `REG_DWELL, 32'h05);
    chk("dwell gated", 1, err);
    apb(0, `REG_DWELL, 0);
    chk("dwell readable", 32'h14, rd[5:0]);
    apb(1, `REG_STATUS, 32'h0);
    chk("status ro", 1, err);
    apb(0, 8'h40, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    pf <= 1'b0;
    cyc(6);
    chk("power back", 32'h01, st);
  endtask

  // Processor watchdog spacing after a kick
  task automatic t_wdog();
    apb(1, `REG_KICK, 32'h0);
    n = 0;
    while (wdr !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk("watchdog period", 1, n > 35 && n < 45);
  endtask

  // Local mode discards updates, override accepts them
  task automatic t_local();
    lsw <= 1'b1;
    cyc(6);
    chk("local state", 32'h02, st);
    n = 0;
    req(1, 8'd2);
    repeat (4) begin
      @(posedge clk);
      n += int'(acc);
    end
    chk("local discard", 0, n);
    ovr <= 1'b1;
    cyc(1);
    ovr <= 1'b0;
    cyc(3);
    chk("override state", 32'h04, st);
    n = 0;
    req(1, 8'd2);
    repeat (4) begin
      @(posedge clk);
      n += int'(acc);
    end
    chk("override accept", 1, n);
    // Local-off leaves override; switch still on, so local follows a cycle later
    loff <= 1'b1;
    cyc(1);
    loff <= 1'b0;
    cyc(1);
    chk("local off", 32'h01, st);
  endtask

  // Main sequence; every input starts defined
  initial begin
    {rstn, psel, penable, pwrite, send, upd, rxd, shw, ovr, tagv, pf, lsw, kon, koff, loff} = '0;
    {paddr, pwdata, dly, tagd} = '0;
    err_count = 0;
    num_checks = 0;
    cyc(20);
    rstn <= 1'b1;
    t_ctrl();
    t_dwell();
    t_disp();
    t_resp();
    t_kpad();
    t_loss();
    t_power();
    t_wdog();
    t_local();
    report_and_stop();
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(40 * 8000);
    err_count++;
    report_and_stop();
  end
endmodule // tb_sign_supervisor
